// [timer_pwm_pkg.sv]
package timer_pwm_pkg;
    // Byte addresses of the word-wide registers
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_CTL1 = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_MATCH = 8'h0C;
    localparam logic [7:0] ADDR_RELOAD = 8'h10;
    localparam logic [7:0] ADDR_PWMCTL = 8'h14;
    // First control register fields
    localparam int CTL0_MODE_HI = 0;
    localparam int CTL0_IRQSRC = 1;
    localparam int CTL0_CAPFLAG = 3;
    // Second control register fields
    localparam int CTL1_MODE = 0;
    localparam int CTL1_PRESC = 3;
    localparam int CTL1_POL = 6;
    localparam int CTL1_EN = 7;
    // Operating modes, high bit then low field
    localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
    localparam logic [3:0] MODE_CAPTURE = 4'h4;
    localparam logic [3:0] MODE_PWM_DUAL = 4'h8;
    // Interrupt source selection codes
    localparam logic [1:0] IRQSRC_BOTH = 2'h0;
    localparam logic [1:0] IRQSRC_CAP_ONLY = 2'h1;
    localparam logic [1:0] IRQSRC_RELOAD_ONLY = 2'h2;
    // Count values and reset values
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] COUNT_RST = 16'h0001;
    localparam logic [15:0] MATCH_RST = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'hFFFF;
    localparam int DEAD_MAX = 128;
    localparam int COUNT_BITS = 16;
endpackage

// [dead_band_delay.sv]
`timescale 1ns/100ps
module dead_band_delay #(
    parameter int DEAD_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lvlIn,
    input wire logic [DEAD_W-1:0] delay,
    output logic lvlOut
);
    // Cycles spent waiting with the input already high
    logic [DEAD_W-1:0] wait_reg;
    logic out_reg;

    // Low goes through at once, high only after the wait
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg <= 1'b0;
            wait_reg <= '0;
        end else if (!lvlIn) begin
            // Falling edge never delayed
            out_reg <= 1'b0;
            wait_reg <= '0;
        end else if (!out_reg) begin
            // Rising edge held back by the programmed wait
            if (wait_reg >= delay) begin
                out_reg <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 1'b1;
            end
        end
    end

    assign lvlOut = out_reg;

    a_fall_fast: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(lvlIn) |=> !lvlOut) else $error("low transition was delayed");
    a_rise_zero: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(lvlIn) && delay == '0 && !lvlOut |=> lvlOut) else $error("zero delay rise late");
    a_rise_held: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(lvlIn) && delay >= DEAD_W'(2) && $stable(delay) |=> !lvlOut ##1 !lvlOut)
        else $error("rise came before the dead band");
endmodule

// [timer_pwm_capture.sv]
`timescale 1ns/100ps
module timer_pwm_capture #(
    parameter int COUNT_W = timer_pwm_pkg::COUNT_BITS,
    parameter int DEAD_MAX = timer_pwm_pkg::DEAD_MAX
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire logic timerIn,
    output logic pwmOut,
    output logic compOut,
    output logic compOe,
    output logic timerIrq
);
    localparam int DEAD_W = $clog2(DEAD_MAX + 1);
    localparam logic [COUNT_W-1:0] RESTART = COUNT_W'(timer_pwm_pkg::COUNT_RESTART);
    localparam logic [DEAD_W-1:0] DEAD_LIMIT = DEAD_W'(DEAD_MAX);

    // Refuse widths the register words cannot carry
    if (COUNT_W < 2 || COUNT_W > 31) begin : g_bad_count
        $error("COUNT_W must be 2 to 31");
    end
    if (DEAD_MAX < 1 || DEAD_MAX > 255) begin : g_bad_dead
        $error("DEAD_MAX must be 1 to 255");
    end

    // Control fields
    logic modeHi_reg; // High mode bit
    logic [1:0] irqSrc_reg; // Interrupt source choice
    logic capFlag_reg; // Last capture-mode event was a capture, not a reload
    logic [2:0] modeLo_reg; // Low mode field
    logic [2:0] presc_reg; // Divide by two to this power
    logic pol_reg; // Output level and capture edge
    logic en_reg; // Timer running
    // Counting state
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] match_reg; // PWM match or captured count
    logic [COUNT_W-1:0] reload_reg;
    logic [DEAD_W-1:0] dead_reg;
    logic [6:0] presCnt_reg; // Prescaler divider
    logic pwmRaw_reg; // Undelayed primary level
    logic inPrev_reg; // Input one cycle ago
    logic irq_reg;
    logic compOe_reg;
    // Bus side
    logic ack_reg;
    logic [31:0] datO_reg;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = d[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Current register words
    logic [31:0] ctl0Word;
    logic [31:0] ctl1Word;
    logic [31:0] countWord;
    logic [31:0] matchWord;
    logic [31:0] reloadWord;
    logic [31:0] deadWord;
    assign ctl0Word = {28'h0, capFlag_reg, irqSrc_reg, modeHi_reg};
    assign ctl1Word = {24'h0, en_reg, pol_reg, presc_reg, modeLo_reg};
    assign countWord = {{(32-COUNT_W){1'b0}}, count_reg};
    assign matchWord = {{(32-COUNT_W){1'b0}}, match_reg};
    assign reloadWord = {{(32-COUNT_W){1'b0}}, reload_reg};
    assign deadWord = {{(32-DEAD_W){1'b0}}, dead_reg};

    // Bus decode; a write lands on the edge at which the master sees ack
    logic access;
    logic wrEn;
    assign access = wbCyc & wbStb;
    assign wrEn = access & wbWe & ack_reg;

    logic wrCtl0;
    logic wrCtl1;
    logic wrCount;
    logic wrMatch;
    logic wrReload;
    logic wrDead;
    assign wrCtl0 = wrEn && wbAdr == timer_pwm_pkg::ADDR_CTL0;
    assign wrCtl1 = wrEn && wbAdr == timer_pwm_pkg::ADDR_CTL1;
    assign wrCount = wrEn && wbAdr == timer_pwm_pkg::ADDR_COUNT;
    assign wrMatch = wrEn && wbAdr == timer_pwm_pkg::ADDR_MATCH;
    assign wrReload = wrEn && wbAdr == timer_pwm_pkg::ADDR_RELOAD;
    assign wrDead = wrEn && wbAdr == timer_pwm_pkg::ADDR_PWMCTL;

    // Merged write words
    logic [31:0] newCtl0;
    logic [31:0] newCtl1;
    logic [31:0] newCount;
    logic [31:0] newMatch;
    logic [31:0] newReload;
    logic [31:0] newDead;
    assign newCtl0 = mergeWord(ctl0Word, wbDatI, wbSel);
    assign newCtl1 = mergeWord(ctl1Word, wbDatI, wbSel);
    assign newCount = mergeWord(countWord, wbDatI, wbSel);
    assign newMatch = mergeWord(matchWord, wbDatI, wbSel);
    assign newReload = mergeWord(reloadWord, wbDatI, wbSel);
    assign newDead = mergeWord(deadWord, wbDatI, wbSel);

    // Read mux, unmapped addresses read zero
    logic [31:0] rdWord;
    always_comb begin
        unique case (wbAdr)
            timer_pwm_pkg::ADDR_CTL0: rdWord = ctl0Word;
            timer_pwm_pkg::ADDR_CTL1: rdWord = ctl1Word;
            timer_pwm_pkg::ADDR_COUNT: rdWord = countWord;
            timer_pwm_pkg::ADDR_MATCH: rdWord = matchWord;
            timer_pwm_pkg::ADDR_RELOAD: rdWord = reloadWord;
            timer_pwm_pkg::ADDR_PWMCTL: rdWord = deadWord;
            default: rdWord = 32'h0;
        endcase
    end

    // Ack one cycle after the request, dropped the next
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
            datO_reg <= 32'h0;
        end else begin
            ack_reg <= access & ~ack_reg;
            if (access && !ack_reg) begin
                datO_reg <= rdWord;
            end
        end
    end
    assign wbAck = ack_reg;
    assign wbDatO = datO_reg;

    // Mode decode
    logic [3:0] mode;
    logic isPwm;
    logic isCap;
    logic isDual;
    assign mode = {modeHi_reg, modeLo_reg};
    assign isDual = mode == timer_pwm_pkg::MODE_PWM_DUAL;
    assign isPwm = en_reg && (isDual || mode == timer_pwm_pkg::MODE_PWM_SINGLE);
    assign isCap = en_reg && mode == timer_pwm_pkg::MODE_CAPTURE;

    // Prescaled count enable, divide by 1 to 128
    logic [6:0] presMask;
    logic tick;
    assign presMask = 7'((8'h01 << presc_reg) - 8'h01);
    assign tick = (isPwm || isCap) && (presCnt_reg & presMask) == presMask;

    // Events of this cycle
    logic atReload;
    logic inEdge;
    logic capEdge;
    assign atReload = tick && count_reg == reload_reg;
    // Polarity one captures rising, zero falling
    assign inEdge = pol_reg ? (timerIn & ~inPrev_reg) : (~timerIn & inPrev_reg);
    assign capEdge = isCap && inEdge;

    // Control registers; the flag is hardware-owned
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modeHi_reg <= 1'b0;
            irqSrc_reg <= timer_pwm_pkg::IRQSRC_BOTH;
            modeLo_reg <= 3'h0;
            presc_reg <= 3'h0;
            pol_reg <= 1'b0;
            en_reg <= 1'b0;
        end else begin
            if (wrCtl0) begin
                modeHi_reg <= newCtl0[timer_pwm_pkg::CTL0_MODE_HI];
                irqSrc_reg <= newCtl0[timer_pwm_pkg::CTL0_IRQSRC +: 2];
            end
            if (wrCtl1) begin
                modeLo_reg <= newCtl1[timer_pwm_pkg::CTL1_MODE +: 3];
                presc_reg <= newCtl1[timer_pwm_pkg::CTL1_PRESC +: 3];
                pol_reg <= newCtl1[timer_pwm_pkg::CTL1_POL];
                en_reg <= newCtl1[timer_pwm_pkg::CTL1_EN];
            end
        end
    end

    // Capture cause: set beats clear when both arrive
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capFlag_reg <= 1'b0;
        end else if (capEdge) begin
            capFlag_reg <= 1'b1;
        end else if (isCap && atReload) begin
            capFlag_reg <= 1'b0;
        end
    end

    // Period and dead band; oversize dead band clamps
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reload_reg <= COUNT_W'(timer_pwm_pkg::RELOAD_RST);
            dead_reg <= '0;
        end else begin
            if (wrReload) begin
                reload_reg <= newReload[COUNT_W-1:0];
            end
            if (wrDead) begin
                if (newDead[DEAD_W-1:0] > DEAD_LIMIT || newDead[31:DEAD_W] != '0) begin
                    dead_reg <= DEAD_LIMIT;
                end else begin
                    dead_reg <= newDead[DEAD_W-1:0];
                end
            end
        end
    end

    // Match: hardware capture wins over a software write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match_reg <= COUNT_W'(timer_pwm_pkg::MATCH_RST);
        end else if (capEdge) begin
            match_reg <= count_reg;
        end else if (wrMatch) begin
            match_reg <= newMatch[COUNT_W-1:0];
        end
    end

    // Divider runs only while counting is possible
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presCnt_reg <= 7'h0;
        end else if (!(isPwm || isCap)) begin
            presCnt_reg <= 7'h0;
        end else begin
            presCnt_reg <= presCnt_reg + 7'h1;
        end
    end

    // Counter; a software write sets the first period only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= COUNT_W'(timer_pwm_pkg::COUNT_RST);
        end else if (wrCount) begin
            count_reg <= newCount[COUNT_W-1:0];
        end else if (tick) begin
            if (isPwm && atReload) begin
                count_reg <= RESTART;
            end else begin
                // Capture mode runs on through reload and wraps
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // Primary level: idle at polarity, flips on the tick that leaves the match count
    // Flipping there keeps the active time at reload minus match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwmRaw_reg <= 1'b0;
        end else if (!isPwm) begin
            pwmRaw_reg <= pol_reg;
        end else if (atReload) begin
            pwmRaw_reg <= pol_reg;
        end else if (tick && count_reg == match_reg) begin
            pwmRaw_reg <= ~pol_reg;
        end
    end

    // Input history for edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inPrev_reg <= 1'b1; // Pin idles at its pull-up, so no false edge after reset
        end else begin
            inPrev_reg <= timerIn;
        end
    end

    // Interrupt pulse, source field filters capture mode
    logic capIrq;
    logic relIrq;
    assign capIrq = capEdge && irqSrc_reg != timer_pwm_pkg::IRQSRC_RELOAD_ONLY;
    assign relIrq = atReload && (isPwm || irqSrc_reg != timer_pwm_pkg::IRQSRC_CAP_ONLY);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= capIrq | relIrq;
        end
    end
    assign timerIrq = irq_reg;

    // Shared pin becomes the complement output in dual mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compOe_reg <= 1'b0;
        end else begin
            compOe_reg <= isDual;
        end
    end
    assign compOe = compOe_reg;

    // Each output has its own delay stage, both fed the same setting so their timing matches
    logic [1:0] lvlRaw;
    logic [1:0] lvlDly;
    logic [DEAD_W-1:0] deadUse;
    assign lvlRaw[0] = pwmRaw_reg;
    assign lvlRaw[1] = isDual & isPwm & ~pwmRaw_reg;
    assign deadUse = isDual ? dead_reg : '0;
    for (genvar ch = 0; ch < 2; ch++) begin : g_dead
        dead_band_delay #(
            .DEAD_W(DEAD_W)
        ) u_dead (
            .clk(clk),
            .rst_b(rst_b),
            .lvlIn(lvlRaw[ch]),
            .delay(deadUse),
            .lvlOut(lvlDly[ch])
        );
    end
    assign pwmOut = lvlDly[0];
    assign compOut = lvlDly[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_reload_restart: assert property (isPwm && atReload && !wrCount |=> count_reg == RESTART)
        else $error("count did not restart at reload");
    a_reload_irq: assert property (isPwm && atReload |=> timerIrq)
        else $error("no interrupt at reload");
    a_match_flip: assert property (isPwm && tick && !atReload &&
        count_reg == match_reg |=> pwmRaw_reg == !pol_reg)
        else $error("output did not flip at match");
    a_period_level: assert property (isPwm && atReload |=> pwmRaw_reg == $past(pol_reg))
        else $error("output not restored at reload");
    a_idle_level: assert property (!isPwm ##1 !isPwm |-> pwmRaw_reg == $past(pol_reg))
        else $error("idle level differs from polarity");
    a_capture_copy: assert property (capEdge |=> match_reg == $past(count_reg))
        else $error("capture did not copy count");
    a_capture_flag: assert property (capEdge |=> capFlag_reg)
        else $error("capture flag not set");
    a_reload_clear: assert property (isCap && atReload && !capEdge |=> !capFlag_reg)
        else $error("capture flag not cleared");
    a_source_mask: assert property (capEdge && !atReload &&
        irqSrc_reg == timer_pwm_pkg::IRQSRC_RELOAD_ONLY |=> !timerIrq)
        else $error("masked capture raised interrupt");
    a_comp_inverse: assert property (isPwm && isDual |-> !(pwmOut && compOut))
        else $error("both outputs active together");
    a_pin_switch: assert property (##1 compOe == $past(isDual))
        else $error("complement pin enable wrong");
    a_no_tick_idle: assert property (!en_reg ##1 !en_reg |-> $stable(count_reg) || $past(wrCount))
        else $error("count moved while disabled");

    c_pwm_reload: cover property (isPwm && atReload);
    c_capture: cover property (capEdge ##[1:600] isCap && atReload);
    c_dead_rise: cover property (isDual && dead_reg > '0 && $rose(compOut));
    c_masked_cap: cover property (capEdge && irqSrc_reg == timer_pwm_pkg::IRQSRC_RELOAD_ONLY);
endmodule

// [gpio_pin_model.sv]
`timescale 1ns/100ps
// Shared timer-input / complement pin, with a weak pull-up on the pad
module gpio_pin_model (
    input wire logic driveEn,
    input wire logic driveLvl,
    input wire logic compOut,
    input wire logic compOe,
    output logic timerIn,
    output logic clash
);
    // Pad level: design first, then outside driver, else the pull-up
    always_comb begin
        if (compOe) begin
            timerIn = compOut;
        end else if (driveEn) begin
            timerIn = driveLvl;
        end else begin
            timerIn = 1'b1;
        end
    end
    // Two drivers on one pad would be a board fault
    assign clash = compOe & driveEn;
endmodule

// [tb_timer_pwm_capture.sv]
`timescale 1ns/100ps
// Self-checking bench for the PWM and capture timer
module tb_timer_pwm_capture;
    logic clk; // System clock
    logic rst_b; // Reset, active low
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel; // Full words but for one lane test
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic wbAck;
    logic timerIn;
    logic pwmOut;
    logic compOut;
    logic compOe;
    logic timerIrq;
    logic driveEn; // Outside driver of the shared pin
    logic driveLvl;
    logic clash;
    int errorCnt = 0;
    int nCompared = 0;
    int clashCnt = 0; // Settled samples with two drivers on the pad

    // Pad contention watch, sampled away from the launching edge
    always @(negedge clk) begin
        if (clash === 1'b1) begin
            clashCnt++;
        end
    end

    timer_pwm_capture i_timer_pwm_capture (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .timerIn(timerIn),
        .pwmOut(pwmOut), .compOut(compOut), .compOe(compOe), .timerIrq(timerIrq));
    gpio_pin_model i_gpio_pin_model (.driveEn(driveEn), .driveLvl(driveLvl), .compOut(compOut),
        .compOe(compOe), .timerIn(timerIn), .clash(clash));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Verdict and end of run
    task automatic test_done();
        $display("Compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // Classic single bus cycle; returns on the edge that saw ack
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        check(32'(wbAck), 32'h1, "bus ack");
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_xfer(1'b1, adr, dat, q);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb_xfer(1'b0, adr, 32'h0, q);
    endtask

    // Outside level on the shared pin
    task automatic drive(input logic en, input logic lvl);
        @(posedge clk);
        driveEn <= en;
        driveLvl <= lvl;
    endtask

    // Disable, program, then enable: the only safe order
    task automatic setup(input logic [3:0] mode, input logic pol, input logic [2:0] p, input logic [1:0] src,
                         input logic [15:0] start, input logic [15:0] match, input logic [15:0] reload);
        wr(timer_pwm_pkg::ADDR_CTL1, 32'h0);
        wr(timer_pwm_pkg::ADDR_CTL0, {29'h0, src, mode[3]});
        wr(timer_pwm_pkg::ADDR_COUNT, {16'h0, start});
        wr(timer_pwm_pkg::ADDR_MATCH, {16'h0, match});
        wr(timer_pwm_pkg::ADDR_RELOAD, {16'h0, reload});
        wr(timer_pwm_pkg::ADDR_CTL1, {24'h0, 1'b1, pol, p, mode[2:0]});
    endtask

    // Waits a bounded number of settled samples for the interrupt
    task automatic wait_irq(input int lim, output bit g, output int t);
        g = 1'b0;
        t = 0;
        while (t < lim && !g) begin
            @(posedge clk);
            #1;
            t++;
            g = (timerIrq === 1'b1);
        end
    endtask

    // Measures one period, from this interrupt sample to the next
    task automatic measure(output int gap, output int hiA, output int hiB, output int ov, output int pm);
        gap = 0;
        hiA = 0;
        hiB = 0;
        ov = 0;
        pm = 0;
        do begin
            hiA += int'(pwmOut === 1'b1);
            hiB += int'(compOut === 1'b1);
            ov += int'(pwmOut === 1'b1 && compOut === 1'b1);
            pm += int'(compOe === 1'b1 && timerIn !== compOut);
            gap++;
            @(posedge clk);
            #1;
        end while (timerIrq !== 1'b1 && gap < 5000);
    endtask

    // Reset values, unmapped place, read-only flag, dead band clamp
    task automatic reg_check();
        logic [31:0] q;
        logic [7:0] adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        logic [31:0] exp [7] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'hFFFF, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd(adr[i], q);
            check(q, exp[i], "reset value");
        end
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, q);
        check(q, 32'h0, "unmapped read");
        wr(timer_pwm_pkg::ADDR_CTL0, 32'hF);
        rd(timer_pwm_pkg::ADDR_CTL0, q);
        check(q, 32'h7, "flag is read-only");
        wr(timer_pwm_pkg::ADDR_CTL0, 32'h0);
        wr(timer_pwm_pkg::ADDR_PWMCTL, 32'd200);
        rd(timer_pwm_pkg::ADDR_PWMCTL, q);
        check(q, 32'd128, "dead band clamp");
        wbSel <= 4'h1;
        wr(timer_pwm_pkg::ADDR_RELOAD, 32'h00001234);
        wbSel <= 4'hF;
        rd(timer_pwm_pkg::ADDR_RELOAD, q);
        check(q, 32'h0000FF34, "byte lane write");
    endtask

    // Mode field alone is not enough: the high bit takes part
    task automatic mode_decode();
        bit g;
        int t;
        setup(4'hB, 1'b0, 3'h0, timer_pwm_pkg::IRQSRC_BOTH, 16'h1, 16'h2, 16'h4);
        wait_irq(30, g, t);
        check(32'(g), 32'h0, "no counting in undefined mode");
    endtask

    // Single output: duty, period, start count, prescale
    task automatic pwm_run(input logic pol, input logic [2:0] p, input int start, input int m, input int r);
        bit g;
        int t, gap, hiA, hiB, ov, pm, per;
        per = r << p;
        setup(timer_pwm_pkg::MODE_PWM_SINGLE, pol, p, timer_pwm_pkg::IRQSRC_BOTH, 16'(start), 16'(m), 16'(r));
        wait_irq(per + 20, g, t);
        check(32'(g), 32'h1, "first reload interrupt");
        if (start > 1) check(32'(t < per), 32'h1, "start count shortens first period");
        repeat (2) begin
            measure(gap, hiA, hiB, ov, pm);
            check(gap, per, "period");
            check(hiA, pol ? m << p : (r - m) << p, "high time");
            check(hiB, 0, "complement idle");
        end
        check(32'(compOe), 32'h0, "pin stays input");
    endtask

    // Dual output: complement, dead band, pin takeover
    task automatic dual_run(input logic pol, input int d, input int m, input int r);
        bit g;
        int t, gap, hiA, hiB, ov, pm;
        drive(1'b0, 1'b0);
        wr(timer_pwm_pkg::ADDR_PWMCTL, 32'(d));
        setup(timer_pwm_pkg::MODE_PWM_DUAL, pol, 3'h0, timer_pwm_pkg::IRQSRC_BOTH, 16'h1, 16'(m), 16'(r));
        check(32'(compOe), 32'h1, "pin turned to output");
        wait_irq(r + 20, g, t);
        measure(gap, hiA, hiB, ov, pm);
        check(gap, r, "dual period");
        check(hiA, (pol ? m : r - m) - d, "primary high");
        check(hiB, (pol ? r - m : m) - d, "complement high");
        check(ov, 0, "outputs overlap");
        check(pm, 0, "pin shows complement");
    endtask

    // Capture: wrong edge ignored, right edge latched, reload clears flag
    task automatic capture_run(input logic pol, input logic [1:0] src);
        bit g;
        int t;
        logic [31:0] q;
        // Leave dual mode so the pad is ours before driving it
        wr(timer_pwm_pkg::ADDR_CTL0, 32'h0);
        drive(1'b1, pol);
        setup(timer_pwm_pkg::MODE_CAPTURE, pol, 3'h7, src, 16'h1, 16'h0, 16'h3);
        drive(1'b1, ~pol);
        wait_irq(6, g, t);
        check(32'(g), 32'h0, "wrong edge ignored");
        rd(timer_pwm_pkg::ADDR_MATCH, q);
        check(q, 32'h0, "no capture on wrong edge");
        drive(1'b1, pol);
        wait_irq(6, g, t);
        check(32'(g), 32'(src != timer_pwm_pkg::IRQSRC_RELOAD_ONLY), "capture interrupt");
        rd(timer_pwm_pkg::ADDR_MATCH, q);
        check(q, 32'h1, "captured count");
        rd(timer_pwm_pkg::ADDR_CTL0, q);
        check(q[3], 1'b1, "cause flag set");
        wait_irq(420, g, t);
        check(32'(g), 32'(src != timer_pwm_pkg::IRQSRC_CAP_ONLY), "reload interrupt");
        rd(timer_pwm_pkg::ADDR_CTL0, q);
        check(q[3], 1'b0, "cause flag cleared");
        rd(timer_pwm_pkg::ADDR_COUNT, q);
        check(q, 32'h4, "count runs on past reload");
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'hF;
        wbDatI = 32'h0;
        driveEn = 1'b0; // Pad left to its pull-up
        driveLvl = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        reg_check();
        mode_decode();
        pwm_run(1'b0, 3'h0, 1, 2, 4);
        pwm_run(1'b1, 3'h0, 19, 5, 20);
        pwm_run(1'b0, 3'h1, 1, 3, 6);
        dual_run(1'b0, 3, 10, 30);
        dual_run(1'b1, 5, 12, 28);
        capture_run(1'b1, timer_pwm_pkg::IRQSRC_BOTH);
        capture_run(1'b0, timer_pwm_pkg::IRQSRC_CAP_ONLY);
        capture_run(1'b1, timer_pwm_pkg::IRQSRC_RELOAD_ONLY);
        check(clashCnt, 0, "pad contention");
        test_done();
    end

    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #(20000 * 100);
        errorCnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end
endmodule
